// file: dv/serial_node.sv
// Purpose: Remote serial node that drives and watches the line
// Assumes: 16 mclk cycles per bit time
// Notes: Line rests at its idle level between frames, high unless inverted
`timescale 1ns/10ps
module serial_node (
    // Clock
    input wire logic mclk,
    // Serial line
    output logic line_out,
    input wire logic line_in
);
    logic idle_lvl;

    initial begin
        idle_lvl = 1'b1;
        line_out = 1'b1;
    end

    // Low idle models an inverting transceiver in front of the node
    task automatic set_idle(input logic v);
        idle_lvl = v;
        line_out <= v;
        @(posedge mclk);
    endtask

    // Bits leave LSB of the vector first; one idle cycle closes each frame
    task automatic send_bits(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i] ^ ~idle_lvl;
            repeat (16) @(posedge mclk);
        end
        line_out <= idle_lvl;
        @(posedge mclk);
    endtask

    // Bounded wait so a silent transmitter cannot hang the run
    // Falling-edge sampling keeps clear of the edge that launches the pin
    task automatic wait_low();
        int t;
        t = 0;
        while (line_in !== 1'b0 && t < 200) begin
            @(negedge mclk);
            t++;
        end
    endtask

    task automatic get_byte(output logic [7:0] d);
        wait_low();
        repeat (8) @(negedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(negedge mclk);
            d[i] = line_in;
        end
    endtask

    task automatic low_run(output int n);
        wait_low();
        n = 0;
        while (line_in === 1'b0 && n < 400) begin
            @(negedge mclk);
            n++;
        end
    endtask
endmodule

// file: dv/tb.sv
// Purpose: Self-checking bench of option, status and receive data
// Assumes: 16 mclk cycles per bit, registers at package addresses
// Notes: Control is dropped to power-only before each mode change
`timescale 1ns/10ps
`define CHK(got, exp) chk(got, exp)
module tb;
    import uart_pkg::*;
    logic mclk, rst_n, wr_en, rd_en, serial_in_pin, serial_out_pin, rx_complete;
    logic [31:0] addr;
    logic [7:0] wr_data, rd_data, d, wr_data_seen;
    int miscompares, cmp_count, rx_cnt, c, n;

    uart_option_status_rxdata uart_option_status_rxdata_inst (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .rx_complete(rx_complete));
    serial_node serial_node_inst (.mclk(mclk), .line_out(serial_in_pin),
        .line_in(serial_out_pin));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (rx_complete === 1'b1) begin
            rx_cnt <= rx_cnt + 1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic mode(input logic [7:0] v);
        wr(CTL_ADDR, 8'h80);
        wr(CTL_ADDR, v);
    endtask

    task automatic t_reset();
        rd(OPT_ADDR, d);
        `CHK(d, OPT_RST);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h00);
        rd(RXB_ADDR, d);
        `CHK(d, 8'hff);
        rd(32'h00000010, d);
        `CHK(d, 8'h00);
        wr(OPT_ADDR, 8'hff);
        rd(OPT_ADDR, d);
        `CHK(d, 8'h1f);
        wr(OPT_ADDR, 8'h14);
        $display("test reset and option layout done");
    endtask

    task automatic t_rx();
        mode(8'hb2);
        c = rx_cnt;
        serial_node_inst.send_bits({1'b1, 8'h5a, 1'b0}, 10);
        settle(4);
        `CHK(rx_cnt - c, 1);
        rd(RXB_ADDR, d);
        `CHK(d, 8'h5a);
        serial_node_inst.send_bits({1'b1, 8'h33, 1'b0}, 10);
        serial_node_inst.send_bits({1'b1, 8'hc3, 1'b0}, 10);
        settle(4);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h01);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h01);
        rd(RXB_ADDR, d);
        `CHK(d, 8'h33);
        wr(STAT_ADDR, 8'h07);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h01);
        wr(STAT_ADDR, 8'hf8);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h00);
        $display("test receive and overrun done");
    endtask

    task automatic t_err();
        mode(8'hbe);
        serial_node_inst.send_bits({1'b1, 1'b0, 8'h01, 1'b0}, 11);
        settle(4);
        rd(STAT_ADDR, d);
        `CHK(d & 8'h04, 8'h04);
        mode(8'hb6);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h00);
        serial_node_inst.send_bits({1'b1, 1'b1, 8'h01, 1'b0}, 11);
        settle(4);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h00);
        rd(RXB_ADDR, d);
        `CHK(d, 8'h01);
        mode(8'hba);
        serial_node_inst.send_bits({1'b1, 1'b0, 8'h01, 1'b0}, 11);
        settle(4);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h00);
        mode(8'hb2);
        serial_node_inst.send_bits({1'b0, 8'h55, 1'b0}, 10);
        settle(300);
        rd(STAT_ADDR, d);
        `CHK(d & 8'h02, 8'h02);
        wr(CTL_ADDR, 8'h80);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h00);
        $display("test receive errors done");
    endtask

    task automatic t_seven();
        mode(8'hb0);
        serial_node_inst.send_bits({1'b1, 7'h6b, 1'b0}, 9);
        settle(4);
        rd(RXB_ADDR, d);
        `CHK(d, 8'h6b);
        mode(8'ha0);
        serial_node_inst.send_bits({1'b1, 7'b1101000, 1'b0}, 9);
        settle(4);
        rd(RXB_ADDR, d);
        `CHK(d, 8'h16);
        $display("test seven-bit alignment done");
    endtask

    // Receive inversion only changes with rx enable off
    task automatic t_inv();
        wr(CTL_ADDR, 8'h80);
        serial_node_inst.set_idle(1'b0);
        wr(OPT_ADDR, 8'h15);
        wr(CTL_ADDR, 8'hb2);
        serial_node_inst.send_bits({1'b1, 8'hc6, 1'b0}, 10);
        settle(4);
        rd(RXB_ADDR, d);
        `CHK(d, 8'hc6);
        wr(CTL_ADDR, 8'h80);
        wr(OPT_ADDR, 8'h14);
        serial_node_inst.set_idle(1'b1);
        $display("test receive inversion done");
    endtask

    task automatic t_tx();
        mode(8'hd2);
        wr(TXB_ADDR, 8'ha5);
        fork
            serial_node_inst.get_byte(wr_data_seen);
            begin
                rd(STAT_ADDR, d);
                `CHK(d & 8'h80, 8'h80);
            end
        join
        `CHK(wr_data_seen, 8'ha5);
        settle(40);
        rd(STAT_ADDR, d);
        `CHK(d, 8'h00);
        // Busy seen clear before the transmitter is reinitialised
        // Inversion changed with tx enable off
        wr(CTL_ADDR, 8'h80);
        wr(OPT_ADDR, 8'h16);
        settle(3);
        `CHK(serial_out_pin, 1'b0);
        wr(CTL_ADDR, 8'h00);
        settle(3);
        `CHK(serial_out_pin, 1'b0);
        rd(RXB_ADDR, d);
        `CHK(d, 8'hff);
        wr(OPT_ADDR, 8'h14);
        settle(3);
        `CHK(serial_out_pin, 1'b1);
        $display("test transmit and levels done");
    endtask

    // Length code 5 gives 13 bits, wrapping through 4 for 20 bits
    // Length only changed with tx enable off
    task automatic t_brk_tx();
        for (int k = 0; k < 8; k++) begin
            wr(CTL_ADDR, 8'h80);
            wr(OPT_ADDR, {3'b000, k[2:0], 2'b00});
            wr(CTL_ADDR, 8'hd2);
            wr(OPT_ADDR, {3'b001, k[2:0], 2'b00});
            serial_node_inst.low_run(n);
            `CHK(n, 16 * (k >= 5 ? k + 8 : k + 16));
            rd(OPT_ADDR, d);
            `CHK(d, {3'b000, k[2:0], 2'b00});
            settle(40);
        end
        wr(CTL_ADDR, 8'h80);
        wr(OPT_ADDR, 8'h14);
        $display("test break transmit done");
    endtask

    task automatic t_brk_rx();
        mode(8'hb2);
        wr(OPT_ADDR, 8'h54);
        rd(OPT_ADDR, d);
        `CHK(d, 8'h94);
        // No trigger is written while the flag is set
        c = rx_cnt;
        serial_node_inst.send_bits(12'h000, 8);
        settle(40);
        rd(OPT_ADDR, d);
        `CHK(d, 8'h94);
        `CHK(rx_cnt - c, 0);
        serial_node_inst.send_bits(12'h000, 12);
        settle(40);
        rd(OPT_ADDR, d);
        `CHK(d, 8'h14);
        `CHK(rx_cnt - c, 1);
        rd(RXB_ADDR, d);
        `CHK(d, 8'hff);
        $display("test break receive done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_rx();
        t_err();
        t_seven();
        t_inv();
        t_tx();
        t_brk_tx();
        t_brk_rx();
        give_verdict();
    end
endmodule

// file: rtl/uart_option_status_rxdata.sv
// Purpose: Option control, status and receive data of a serial channel
// Assumes: Single clock; serial input synchronous to mclk
// Notes: Power-off acts as a synchronous clear to avoid a gated reset
`timescale 1ns/10ps
// Function
// - Option register is 8 bits, resets to 14h.
// - Option bits: flag 7, rx trigger 6, tx trigger 5, length 4..2, tx inv 1, rx inv 0.
// - Break-receive flag reads 1 during break reception; clears on power/enable off or success.
// - A short break keeps the flag set and waits for a new break.
// - Writing 1 to rx trigger starts break reception; reads 0; needs power and rx enable.
// - Writing 1 to tx trigger starts break transmission; reads 0; needs power and tx enable.
// - Length code 101..100 selects 13 to 20 low bit times.
// - Tx inversion bit inverts the transmit pin.
// - Rx inversion bit inverts the receive pin before sampling; changed only when idle.
// - Status resets to 00h: busy 7, zeros 6..3, parity 2, framing 1, overrun 0.
// - Error flags clear on written 0, keep on written 1; busy ignores writes.
// - Busy sets on tx buffer write; clears when disabled or done with nothing queued.
// - Parity error sets when received parity disagrees with selected odd or even parity.
// - Framing error checks only the first stop bit.
// - A character arriving while the buffer is unread sets overrun and is dropped.
// - Error flags clear whenever power or rx enable is 0.
// - Each character received with the buffer empty loads the rx buffer; 7-bit data aligned by bit order.
// - Rx buffer is read-only, FFh at reset and when power clears.
// - Power off resets the channel; pin idles high, low if inverted.
// - Zero-parity reception never sets the parity error.
module uart_option_status_rxdata
    import uart_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [uart_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Serial line
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    // Receive event
    output logic rx_complete
);
    import uart_pkg::*;

    ctl_t ctl_q;
    opt_t opt_q;
    logic busy_q, pe_q, fe_q, ove_q;
    logic [7:0] rxb_q, txb_q, rd_data_q;
    logic rx_full_q, tx_full_q, brk_pend_q, out_q, rx_complete_q;
    rx_state_t rst_q;
    tx_state_t tst_q;
    logic [3:0] rcnt_q, tcnt_q;
    logic [3:0] rbit_q, tbit_q;
    logic [4:0] low_q, blen_q;
    logic [7:0] rsh_q, tsh_q;
    logic rpar_q, tpar_q, stop2_q;

    wire rx_on = ctl_q.pwr & ctl_q.rxe;
    wire tx_on = ctl_q.pwr & ctl_q.txe;
    wire rx_in = serial_in_pin ^ opt_q.rdl;
    wire wr_ctl = wr_en && addr == CTL_ADDR;
    wire wr_opt = wr_en && addr == OPT_ADDR;
    wire wr_stat = wr_en && addr == STAT_ADDR;
    wire wr_txb = wr_en && addr == TXB_ADDR;
    wire rd_rxb = rd_en && addr == RXB_ADDR;
    wire rtick = rcnt_q == 4'h0;
    wire ttick = tcnt_q == 4'h0;
    wire [3:0] last_bit = ctl_q.cl ? 4'h7 : 4'h6;
    wire [4:0] brk_len = BRK_BASE + {2'b00, opt_q.sbl + BRK_OFS};

    // Receive completion events
    logic frame_end, brk_ok;
    logic [7:0] rx_data;
    logic par_bad;
    assign frame_end = rx_on && rst_q == R_STOP && rtick;
    assign brk_ok = rx_on && rst_q == R_BRK && rtick && rx_in && low_q >= BRK_MIN;
    // 7-bit data realigned by transfer order
    assign rx_data = ctl_q.cl ? rsh_q : (ctl_q.dir ? rsh_q >> 1 : rsh_q << 1);
    // Odd/even checked; zero and none skip
    assign par_bad = ctl_q.ps[1] & ((^rx_data) ^ rpar_q ^ ~ctl_q.ps[0]);

    // Control register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= ctl_t'(CTL_RST);
        end else if (wr_ctl) begin
            ctl_q <= ctl_t'(wr_data);
        end
    end

    // Option register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            opt_q <= opt_t'(OPT_RST);
        end else begin
            if (wr_opt) begin
                opt_q.sbl <= wr_data[4:2];
                opt_q.tdl <= wr_data[1];
                opt_q.rdl <= wr_data[0];
            end
            opt_q.srt <= 1'b0;
            opt_q.stt <= 1'b0;
            // Trigger set wins over the success clear
            if (wr_opt && wr_data[OPT_SRT_BIT] && rx_on) begin
                opt_q.srf <= 1'b1;
            end else if (!rx_on || brk_ok) begin
                opt_q.srf <= 1'b0;
            end
        end
    end

    // Receiver
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= R_IDLE;
            rcnt_q <= 4'h0;
            rbit_q <= 4'h0;
            low_q <= 5'h00;
            rsh_q <= 8'h00;
            rpar_q <= 1'b0;
        end else if (!rx_on) begin
            rst_q <= R_IDLE;
            rcnt_q <= 4'h0;
        end else if (rst_q == R_IDLE) begin
            if (!rx_in) begin
                rst_q <= R_START;
                rcnt_q <= HALF_BIT;
            end
        end else if (!rtick) begin
            rcnt_q <= rcnt_q - 4'h1;
        end else begin
            rcnt_q <= BIT_CYCLES;
            case (rst_q)
                R_START: begin
                    rbit_q <= 4'h0;
                    low_q <= 5'h01;
                    if (rx_in) begin
                        rst_q <= R_IDLE;
                    end else if (opt_q.srf) begin
                        rst_q <= R_BRK;
                    end else begin
                        rst_q <= R_DATA;
                    end
                end
                R_DATA: begin
                    rsh_q <= ctl_q.dir ? {rx_in, rsh_q[7:1]} : {rsh_q[6:0], rx_in};
                    rbit_q <= rbit_q + 4'h1;
                    if (rbit_q == last_bit) begin
                        rst_q <= (ctl_q.ps == 2'b00) ? R_STOP : R_PAR;
                    end
                end
                R_PAR: begin
                    rpar_q <= rx_in;
                    rst_q <= R_STOP;
                end
                R_BRK: begin
                    // Short break just returns to waiting
                    if (!rx_in) begin
                        low_q <= (low_q == 5'h1f) ? low_q : low_q + 5'h01;
                    end else begin
                        rst_q <= R_IDLE;
                    end
                end
                default: rst_q <= R_IDLE;
            endcase
        end
    end

    // Status flags and receive buffer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pe_q <= 1'b0;
            fe_q <= 1'b0;
            ove_q <= 1'b0;
            rxb_q <= RXB_RST;
            rx_full_q <= 1'b0;
            rx_complete_q <= 1'b0;
        end else if (!rx_on) begin
            pe_q <= 1'b0;
            fe_q <= 1'b0;
            ove_q <= 1'b0;
            rx_full_q <= 1'b0;
            rx_complete_q <= 1'b0;
            if (!ctl_q.pwr) begin
                rxb_q <= RXB_RST;
            end
        end else begin
            // Break frames bypass error checks and the buffer
            rx_complete_q <= brk_ok || (frame_end && !opt_q.srf);
            // Hardware set wins over a written 0
            pe_q <= (pe_q & ~(wr_stat & ~wr_data[2])) | (frame_end & par_bad);
            fe_q <= (fe_q & ~(wr_stat & ~wr_data[1])) | (frame_end & ~rx_in);
            ove_q <= (ove_q & ~(wr_stat & ~wr_data[0])) | (frame_end & rx_full_q);
            if (frame_end && !rx_full_q) begin
                rxb_q <= rx_data;
                rx_full_q <= 1'b1;
            end else if (rd_rxb) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // Transmit buffer and busy flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txb_q <= TXB_RST;
            tx_full_q <= 1'b0;
            busy_q <= 1'b0;
            brk_pend_q <= 1'b0;
        end else begin
            if (wr_txb) begin
                txb_q <= wr_data;
            end
            if (!tx_on) begin
                tx_full_q <= 1'b0;
                busy_q <= 1'b0;
                brk_pend_q <= 1'b0;
            end else begin
                if (wr_txb) begin
                    tx_full_q <= 1'b1;
                end else if (tst_q == T_IDLE && ttick && !brk_pend_q) begin
                    tx_full_q <= 1'b0;
                end
                if (wr_txb) begin
                    busy_q <= 1'b1;
                end else if (tst_q == T_STOP && ttick && !stop2_q && !tx_full_q) begin
                    busy_q <= 1'b0;
                end
                if (wr_opt && wr_data[OPT_STT_BIT]) begin
                    brk_pend_q <= 1'b1;
                end else if (tst_q == T_IDLE && ttick) begin
                    brk_pend_q <= 1'b0;
                end
            end
        end
    end

    // Transmitter; break has priority over queued data
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tst_q <= T_IDLE;
            tcnt_q <= 4'h0;
            tbit_q <= 4'h0;
            blen_q <= 5'h00;
            tsh_q <= 8'h00;
            tpar_q <= 1'b0;
            stop2_q <= 1'b0;
        end else if (!tx_on) begin
            tst_q <= T_IDLE;
            tcnt_q <= 4'h0;
        end else begin
            tcnt_q <= ttick ? BIT_CYCLES : tcnt_q - 4'h1;
            if (ttick) begin
                case (tst_q)
                    T_IDLE: begin
                        if (brk_pend_q) begin
                            tst_q <= T_BRK;
                            blen_q <= brk_len - 5'h01;
                        end else if (tx_full_q) begin
                            tst_q <= T_START;
                            tsh_q <= txb_q;
                            tpar_q <= ctl_q.ps[1] & ~(^(txb_q & (ctl_q.cl ? 8'hff :
                                (ctl_q.dir ? 8'h7f : 8'hfe))) ^ ctl_q.ps[0]);
                        end
                    end
                    T_START: begin
                        tst_q <= T_DATA;
                        tbit_q <= 4'h0;
                    end
                    T_DATA: begin
                        tsh_q <= ctl_q.dir ? tsh_q >> 1 : tsh_q << 1;
                        tbit_q <= tbit_q + 4'h1;
                        if (tbit_q == last_bit) begin
                            tst_q <= (ctl_q.ps == 2'b00) ? T_STOP : T_PAR;
                            stop2_q <= ctl_q.sl;
                        end
                    end
                    T_PAR: begin
                        tst_q <= T_STOP;
                        stop2_q <= ctl_q.sl;
                    end
                    T_BRK: begin
                        blen_q <= blen_q - 5'h01;
                        if (blen_q == 5'h00) begin
                            tst_q <= T_STOP;
                            stop2_q <= 1'b0;
                        end
                    end
                    T_STOP: begin
                        stop2_q <= 1'b0;
                        if (!stop2_q) begin
                            tst_q <= T_IDLE;
                        end
                    end
                    default: tst_q <= T_IDLE;
                endcase
            end
        end
    end

    // Line level before inversion
    logic tx_line;
    always_comb begin
        case (tst_q)
            T_START: tx_line = 1'b0;
            T_DATA: tx_line = ctl_q.dir ? tsh_q[0] : tsh_q[7];
            T_PAR: tx_line = tpar_q;
            T_BRK: tx_line = 1'b0;
            default: tx_line = 1'b1;
        endcase
    end

    // Pin register; idle high or inverted while off
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 1'b1;
        end else begin
            out_q <= (tx_on ? tx_line : 1'b1) ^ opt_q.tdl;
        end
    end

    // Read port; data valid only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else if (!rd_en) begin
            rd_data_q <= 8'h00;
        end else begin
            case (addr)
                CTL_ADDR: rd_data_q <= ctl_q;
                OPT_ADDR: rd_data_q <= {opt_q.srf, 2'b00, opt_q.sbl, opt_q.tdl, opt_q.rdl};
                STAT_ADDR: rd_data_q <= {busy_q, 4'h0, pe_q, fe_q, ove_q};
                RXB_ADDR: rd_data_q <= rxb_q;
                TXB_ADDR: rd_data_q <= txb_q;
                default: rd_data_q <= 8'h00;
            endcase
        end
    end

    assign rd_data = rd_data_q;
    assign serial_out_pin = out_q;
    assign rx_complete = rx_complete_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    trig_read_zero_a: assert property (rd_en && addr == OPT_ADDR |=> rd_data[6:5] == 2'b00)
        else $error("break trigger read as one");
    stat_zero_bits_a: assert property (rd_en && addr == STAT_ADDR |=> rd_data[6:3] == 4'h0)
        else $error("status reserved bits nonzero");
    pin_idle_off_a: assert property (!ctl_q.pwr ##1 !ctl_q.pwr |=> serial_out_pin == !$past(opt_q.tdl))
        else $error("pin not idle with power off");
    busy_off_a: assert property (!tx_on |=> !busy_q)
        else $error("busy survives tx disable");
    rxb_power_ff_a: assert property (!ctl_q.pwr |=> rxb_q == RXB_RST)
        else $error("receive buffer not FF after power off");
    err_clear_off_a: assert property (!ctl_q.rxe |=> {pe_q, fe_q, ove_q} == 3'b000)
        else $error("error flags survive rx disable");
    overrun_keep_a: assert property (frame_end && rx_full_q && !opt_q.srf |=> ove_q && $stable(rxb_q))
        else $error("overrun mishandled");
    busy_on_write_a: assert property (wr_txb && tx_on && ctl_q.txe |=> busy_q)
        else $error("busy not set on tx write");
    zero_par_pe_a: assert property (ctl_q.ps == PAR_ZERO && !pe_q ##1 ctl_q.ps == PAR_ZERO |-> !pe_q)
        else $error("parity error with zero parity");
    pin_invert_a: assert property (tx_on |=> serial_out_pin == ($past(tx_line) ^ $past(opt_q.tdl)))
        else $error("transmit level wrong");
    brk_len_a: assert property ($rose(tst_q == T_BRK) |-> blen_q == brk_len - 5'h01)
        else $error("break length wrong");
    brk_keep_a: assert property (rst_q == R_BRK && rtick && rx_in && low_q < BRK_MIN && rx_on |=> opt_q.srf)
        else $error("break flag dropped on short break");

    rx_char_c: cover property (frame_end && !rx_full_q && !opt_q.srf);
    brk_rx_c: cover property (brk_ok);
    brk_tx_c: cover property (tst_q == T_BRK ##1 tst_q == T_STOP);
    overrun_c: cover property ($rose(ove_q));
endmodule

// file: rtl/uart_pkg.sv
// Purpose: Shared constants and types for the serial option/status block
// Assumes: 8-bit registers on a 32-bit address port
// Notes: Bit time is a fixed count; a real baud generator lives elsewhere
package uart_pkg;
    localparam int ADDR_W = 32;
    localparam logic [31:0] CTL_ADDR = 32'hfffffa00;
    localparam logic [31:0] OPT_ADDR = 32'h0ffffa03;
    localparam logic [31:0] STAT_ADDR = 32'hfffffa04;
    localparam logic [31:0] RXB_ADDR = 32'hfffffa06;
    localparam logic [31:0] TXB_ADDR = 32'hfffffa07;
    localparam logic [7:0] CTL_RST = 8'h10;
    localparam logic [7:0] OPT_RST = 8'h14;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] RXB_RST = 8'hff;
    localparam logic [7:0] TXB_RST = 8'hff;
    localparam int OPT_SRT_BIT = 6;
    localparam int OPT_STT_BIT = 5;
    localparam int STAT_BUSY_BIT = 7;
    localparam logic [3:0] BIT_CYCLES = 4'hf;
    localparam logic [3:0] HALF_BIT = 4'h7;
    localparam logic [4:0] BRK_MIN = 5'h0b;
    localparam logic [4:0] BRK_BASE = 5'h0d;
    localparam logic [2:0] BRK_OFS = 3'h3;
    localparam logic [1:0] PAR_ZERO = 2'h1;

    typedef struct packed {
        logic pwr;
        logic txe;
        logic rxe;
        logic dir;
        logic [1:0] ps;
        logic cl;
        logic sl;
    } ctl_t;

    typedef struct packed {
        logic srf;
        logic srt;
        logic stt;
        logic [2:0] sbl;
        logic tdl;
        logic rdl;
    } opt_t;

    typedef enum logic [2:0] {
        R_IDLE = 3'b000, R_START = 3'b001, R_DATA = 3'b010,
        R_PAR = 3'b011, R_STOP = 3'b100, R_BRK = 3'b101
    } rx_state_t;

    typedef enum logic [2:0] {
        T_IDLE = 3'b000, T_START = 3'b001, T_DATA = 3'b010,
        T_PAR = 3'b011, T_STOP = 3'b100, T_BRK = 3'b101
    } tx_state_t;
endpackage
